// [hdl/cic_regs.vh]
`ifndef CIC_REGS_VH
`define CIC_REGS_VH
// Port select (address line)
`define CIC_PORT_LOW        1'b0
`define CIC_PORT_HIGH       1'b1
// Mode word fields
`define CIC_MODE_INIT_BIT   4
`define CIC_MODE_NEED4_BIT  0
`define CIC_MODE_SINGLE_BIT 1
`define CIC_MODE_LEVEL_BIT  3
// Processor mode word fields
`define CIC_PM_WIDE_BIT     0
`define CIC_PM_AUTOEOI_BIT  1
`define CIC_PM_BUF_LO_BIT   2
`define CIC_PM_BUF_HI_BIT   3
`define CIC_PM_SFNM_BIT     4
// Operation command values
`define CIC_CMD_NS_EOI      8'h20
`define CIC_CMD_SEL_MASK    8'h18
`define CIC_CMD_SEL_OPERATION_COMMAND_WORD    8'h00
// Reset values
`define CIC_MASK_RESET      8'h00
`define CIC_BYTE_ZERO       8'h00
`define CIC_VEC_LOW_MASK    8'hf8
// Glitch input number
`define CIC_GLITCH_IN       3'h7
// Init sequence states
`define CIC_ST_READY        3'h0
`define CIC_ST_BASE         3'h1
`define CIC_ST_CASC         3'h2
`define CIC_ST_PMODE        3'h3
`endif

// [hdl/cic_prio.v]
`timescale 1ns/1ps
`default_nettype none
// Lowest-numbered set bit wins (input 0 highest)
module cic_prio (
    input  wire [7:0] vec_i,
    output reg        any_o,
    output reg  [2:0] num_o
);
    integer k;
    always @* begin
        any_o = 1'b0;
        num_o = 3'h0;
        for (k = 7; k >= 0; k = k - 1) begin
            if (vec_i[k]) begin
                any_o = 1'b1;
                num_o = k[2:0];
            end
        end
    end
endmodule // cic_prio
`default_nettype wire

// [hdl/cic_core.v]
// Summary of operation
// - Low port bit4 write starts initialization
// - Mode bit0 set expects processor word
// - Mode bit1 clear means cascade word
// - Mode bit3 clear selects edge triggering
// - First high write stores base vector
// - Vector is base ORed input number
// - Cascade mode: second high write cascade
// - Master: cascade bits mark slave inputs
// - Slave: cascade word holds 3-bit identity
// - Processor word bit0 selects wide protocol
// - No auto clear; only EOI or starting initialization clears
// - Bits2,3 nonbuffered; bit4 special nesting off
// - Starting initialization clears the mask
// - Later high writes load the mask
// - Mask bit masks input; readable
// - Lost request answers input 7, no service
// - Fully nested: highest pending first
// - Nonspecific EOI clears highest in-service
// - Higher request re-raises request output
// - Nonspecific EOI command is 0x20
// - First acknowledge sets service, clears edge-mode request
`timescale 1ns/1ps
`default_nettype none
`include "cic_regs.vh"
module cic_core (
    input  wire       core_clk_i,
    input  wire       rstn_i,
    input  wire       wr_i,
    input  wire       rd_i,
    input  wire       addr_i,
    input  wire [7:0] wdata_i,
    input  wire       slave_sel_i,
    input  wire [7:0] irq_i,
    input  wire       ack_i,
    input  wire [2:0] cas_i,
    output reg  [7:0] rdata_o,
    output reg        int_o,
    output reg  [7:0] vec_o,
    output reg        vec_valid_o,
    output reg  [2:0] cas_o,
    output reg        cas_oe_o,
    output reg        wide_mode_o,
    output reg  [7:0] isr_o
);
    reg  [2:0] init_st_reg;
    reg  [7:0] mode_reg;
    reg  [7:0] base_reg;
    reg  [7:0] casc_reg;
    reg  [7:0] pmode_reg;
    reg  [7:0] mask_reg;
    reg  [7:0] irr_reg;
    reg  [7:0] isr_reg;
    reg  [7:0] irq_prev_reg;
    reg        ack_prev_reg;
    reg        ack_phase_reg;
    reg  [2:0] sel_reg;
    reg        sel_valid_reg;
    reg  [7:0] isr_next;
    reg        int_next;
    reg  [7:0] rdata_next;

    function [7:0] onehot;
        input [2:0] n;
        begin
            onehot = 8'h01 << n;
        end
    endfunction

    function port_is;
        input a;
        input p;
        begin
            port_is = (a == p);
        end
    endfunction

    // Vector of one input: base with input number
    function [7:0] vec_of;
        input [2:0] n;
        begin
            vec_of = base_reg | {5'h00, n};
        end
    endfunction

    // Port and command decode
    wire       wr_low   = wr_i && port_is(addr_i, `CIC_PORT_LOW);
    wire       wr_high  = wr_i && port_is(addr_i, `CIC_PORT_HIGH);
    wire       init_go  = wr_low && wdata_i[`CIC_MODE_INIT_BIT];
    wire       eoi_cmd  = wr_low && !wdata_i[`CIC_MODE_INIT_BIT] &&
                          (wdata_i == `CIC_CMD_NS_EOI);
    wire       level    = mode_reg[`CIC_MODE_LEVEL_BIT];
    wire       cascaded = !mode_reg[`CIC_MODE_SINGLE_BIT];
    wire       slave_hit = !cascaded ||
                           (cas_i == casc_reg[2:0]);
    wire       ack_rise = ack_i && !ack_prev_reg;
    wire       ack_take = ack_rise && !ack_phase_reg;
    wire       ack_give = ack_rise && ack_phase_reg;
    wire [7:0] edge_hit = irq_i & ~irq_prev_reg;
    wire [7:0] req_vec  = level ? irq_i : irr_reg;
    wire [7:0] pend     = req_vec & ~mask_reg;
    wire       p_any;
    wire [2:0] p_num;
    wire       s_any;
    wire [2:0] s_num;
    wire       p_beats;
    wire [7:0] casc_eff;
    wire [7:0] irr_set;
    wire [7:0] irr_clr;

    cic_prio u_pend (
        .vec_i (pend),
        .any_o (p_any),
        .num_o (p_num)
    );
    cic_prio u_serv (
        .vec_i (isr_reg),
        .any_o (s_any),
        .num_o (s_num)
    );

    // In-service inputs block equal and lower priority
    assign p_beats  = p_any && (!s_any || (p_num < s_num));
    assign casc_eff = cascaded ? casc_reg : `CIC_BYTE_ZERO;

    // Per-input request latch controls
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_req
            assign irr_set[gi] = !level && edge_hit[gi];
            assign irr_clr[gi] = ack_take && p_any && !level &&
                                 (p_num == gi);
        end
    endgenerate

    // In-service update: acknowledge set after EOI clear
    always @* begin
        isr_next = isr_reg;
        if (eoi_cmd && s_any)
            isr_next = isr_next & ~onehot(s_num);
        if (ack_take && p_any)
            isr_next = isr_next | onehot(p_num);
    end

    // Request output held off during init and acknowledge
    always @* begin
        int_next = (init_st_reg == `CIC_ST_READY) && p_beats &&
                   !ack_phase_reg;
        if (ack_take)
            int_next = 1'b0;
    end

    // Read port select
    always @* begin
        rdata_next = rdata_o;
        if (rd_i)
            rdata_next = port_is(addr_i, `CIC_PORT_HIGH) ? mask_reg
                                                         : isr_reg;
    end

    // Initialization sequencer
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            init_st_reg <= `CIC_ST_READY;
            mode_reg    <= `CIC_BYTE_ZERO;
            base_reg    <= `CIC_BYTE_ZERO;
            casc_reg    <= `CIC_BYTE_ZERO;
            pmode_reg   <= `CIC_BYTE_ZERO;
            mask_reg    <= `CIC_MASK_RESET;
        end else if (init_go) begin
            mode_reg    <= wdata_i;
            mask_reg    <= `CIC_MASK_RESET;
            pmode_reg   <= `CIC_BYTE_ZERO;
            init_st_reg <= `CIC_ST_BASE;
        end else if (wr_high) begin
            case (init_st_reg)
                `CIC_ST_BASE: begin
                    base_reg <= wdata_i;
                    if (cascaded)
                        init_st_reg <= `CIC_ST_CASC;
                    else if (mode_reg[`CIC_MODE_NEED4_BIT])
                        init_st_reg <= `CIC_ST_PMODE;
                    else
                        init_st_reg <= `CIC_ST_READY;
                end
                `CIC_ST_CASC: begin
                    casc_reg <= wdata_i;
                    if (mode_reg[`CIC_MODE_NEED4_BIT])
                        init_st_reg <= `CIC_ST_PMODE;
                    else
                        init_st_reg <= `CIC_ST_READY;
                end
                `CIC_ST_PMODE: begin
                    pmode_reg   <= wdata_i;
                    init_st_reg <= `CIC_ST_READY;
                end
                `CIC_ST_READY: begin
                    mask_reg <= wdata_i;
                end
                default: begin
                    init_st_reg <= `CIC_ST_READY;
                end
            endcase
        end
    end

    // Input and acknowledge history for edge detection
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            irq_prev_reg <= `CIC_BYTE_ZERO;
            ack_prev_reg <= 1'b0;
        end else begin
            irq_prev_reg <= irq_i;
            ack_prev_reg <= ack_i;
        end
    end

    // Request and in-service registers
    always @(posedge core_clk_i) begin
        if (!rstn_i || init_go) begin
            irr_reg <= `CIC_BYTE_ZERO;
            isr_reg <= `CIC_BYTE_ZERO;
        end else begin
            // Edge capture: set wins over acknowledge clear
            irr_reg <= (irr_reg & ~irr_clr) | irr_set;
            isr_reg <= isr_next;
        end
    end

    // Acknowledge phase, selection and request output
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ack_phase_reg <= 1'b0;
            sel_reg       <= 3'h0;
            sel_valid_reg <= 1'b0;
            int_o         <= 1'b0;
        end else if (init_go) begin
            ack_phase_reg <= 1'b0;
            sel_valid_reg <= 1'b0;
            int_o         <= 1'b0;
        end else begin
            int_o <= int_next;
            if (ack_take) begin
                ack_phase_reg <= 1'b1;
                if (p_any) begin
                    sel_reg       <= p_num;
                    sel_valid_reg <= 1'b1;
                end else begin
                    sel_reg       <= `CIC_GLITCH_IN;
                    sel_valid_reg <= 1'b0;
                end
            end else if (ack_give) begin
                ack_phase_reg <= 1'b0;
            end
        end
    end

    // Second acknowledge: vector or cascade address
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            vec_o       <= `CIC_BYTE_ZERO;
            vec_valid_o <= 1'b0;
            cas_o       <= 3'h0;
            cas_oe_o    <= 1'b0;
        end else if (init_go) begin
            vec_valid_o <= 1'b0;
            cas_oe_o    <= 1'b0;
        end else begin
            vec_valid_o <= 1'b0;
            if (ack_give) begin
                if (slave_sel_i) begin
                    if (slave_hit) begin
                        vec_o       <= vec_of(sel_reg);
                        vec_valid_o <= 1'b1;
                    end
                end else if (casc_eff[sel_reg] && sel_valid_reg) begin
                    cas_o    <= sel_reg;
                    cas_oe_o <= 1'b1;
                end else begin
                    vec_o       <= vec_of(sel_reg);
                    vec_valid_o <= 1'b1;
                end
            end else if (!ack_i && !ack_phase_reg) begin
                cas_oe_o <= 1'b0;
            end
        end
    end

    // Register read data
    always @(posedge core_clk_i) begin
        if (!rstn_i)
            rdata_o <= `CIC_BYTE_ZERO;
        else
            rdata_o <= rdata_next;
    end

    // Processor mode status
    always @(posedge core_clk_i) begin
        if (!rstn_i)
            wide_mode_o <= 1'b0;
        else
            wide_mode_o <= pmode_reg[`CIC_PM_WIDE_BIT];
    end

    // In-service copy
    always @(posedge core_clk_i) begin
        if (!rstn_i)
            isr_o <= `CIC_BYTE_ZERO;
        else
            isr_o <= isr_reg;
    end
endmodule // cic_core
`default_nettype wire

// [tb/cic_props.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_props (
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic       wr_i,
    input wire logic       addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       ack_i,
    input wire logic       int_o,
    input wire logic       vec_valid_o,
    input wire logic       wide_mode_o,
    input wire logic [7:0] isr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_init_quiet: assert property (
        wr_i && !addr_i && wdata_i[4] |=> !int_o [*3])
        else $error("request raised during init");
    a_eoi_clear: assert property (
        wr_i && !addr_i && wdata_i == 8'h20 && !ack_i
        |-> ##2 isr_o == ($past(isr_o) & ($past(isr_o) - 8'h01)))
        else $error("wrong in-service bit cleared");
    a_vec_pulse: assert property (vec_valid_o |=> !vec_valid_o)
        else $error("vector strobe too long");
    a_vec_on_ack: assert property (
        vec_valid_o |-> $past(ack_i) || $past(ack_i, 2) || $past(ack_i, 3))
        else $error("vector without acknowledge");
    a_ack_drops_int: assert property (
        $rose(ack_i) && int_o |-> ##[1:3] !int_o)
        else $error("request held after acknowledge");
    a_ack_sets_isr: assert property (
        $rose(ack_i) && int_o && isr_o == 8'h00 |-> ##[1:3] $onehot(isr_o))
        else $error("acknowledge marked no single input");
    a_isr_on_ack: assert property (
        $countones(isr_o) > $countones($past(isr_o))
        |-> $past(ack_i) || $past(ack_i, 2))
        else $error("in-service set without acknowledge");
    a_wide_by_write: assert property (
        $changed(wide_mode_o) |-> $past(wr_i, 2))
        else $error("processor mode changed without write");
endmodule // cic_props
bind cic_core cic_props cic_props_i (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .ack_i(ack_i), .int_o(int_o),
    .vec_valid_o(vec_valid_o), .wide_mode_o(wide_mode_o), .isr_o(isr_o));
`default_nettype wire

// [tb/cic_host.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_host (
    input  wire logic       core_clk_i,
    output var  logic       wr_o = 1'b0,
    output var  logic       rd_o = 1'b0,
    output var  logic       addr_o = 1'b0,
    output var  logic [7:0] wdata_o = 8'h00,
    output var  logic       ack_o = 1'b0
);
    task automatic put(input logic a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d; // Idle bus never repeats data
    endtask
    task automatic get(input logic a);
        @(posedge core_clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
    endtask
    task automatic ack2();
        repeat (2) begin
            @(posedge core_clk_i);
            ack_o <= 1'b1;
            @(posedge core_clk_i);
            ack_o <= 1'b0;
        end
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic init(input logic [7:0] m, b);
        put(1'b0, m);
        put(1'b1, b);
        if (!m[1]) put(1'b1, 8'h04);
        if (m[0]) put(1'b1, 8'h01);
    endtask
    task automatic eoi();
        put(1'b0, 8'h20);
    endtask
endmodule // cic_host
`default_nettype wire

// [tb/cic_core_test.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_core_test;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       wr, rd, addr, ack, intr, vv, wide, rd_d = 1'b0;
    logic [7:0] wd, rdat, vec, in_service_register, irq = 8'h00, rnd = 8'h55;
    logic [7:0] exp_q[$];
    logic [2:0] cas;
    logic       coe;
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    always #4 clk = ~clk;
    cic_host cic_host_i (.core_clk_i(clk), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wd), .ack_o(ack));
    cic_core cic_core_i (.core_clk_i(clk), .rstn_i(rstn), .wr_i(wr),
        .rd_i(rd), .addr_i(addr), .wdata_i(wd), .slave_sel_i(1'b0),
        .irq_i(irq), .ack_i(ack), .cas_i(3'h0), .rdata_o(rdat),
        .int_o(intr), .vec_o(vec), .vec_valid_o(vv), .cas_o(cas),
        .cas_oe_o(coe), .wide_mode_o(wide), .isr_o(in_service_register));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] pop();
        return exp_q.size() ? exp_q.pop_front() : 8'hxx;
    endfunction
    task automatic chk(input string n, input logic [7:0] s, e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic irq_set(input logic [7:0] v);
        @(posedge clk);
        irq <= v;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic ack_exp(input logic [7:0] v);
        exp_q.push_back(v);
        cic_host_i.ack2();
        @(negedge clk);
    endtask
    task automatic rd_exp(input logic [7:0] v);
        exp_q.push_back(v);
        cic_host_i.get(1'b1);
    endtask
    always @(posedge clk) begin
        rd_d <= rd;
        cyc <= cyc + 1;
        if (rd_d) chk("mask", rdat, pop());
        if (vv) chk("vector", vec, pop());
        if (coe) chk("cascade", {5'h0, cas}, pop());
        if (cyc == 2500) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        cic_host_i.init(8'h11, 8'h20);
        repeat (2) @(negedge clk);
        chk("wide", {7'h0, wide}, 8'h01);
        rd_exp(8'h00);
        cic_host_i.put(1'b1, 8'h00);
        irq_set(8'h28);
        chk("int", {7'h0, intr}, 8'h01);
        ack_exp(8'h23);
        chk("isr", in_service_register, 8'h08);
        irq_set(8'h2a);
        chk("int", {7'h0, intr}, 8'h01);
        ack_exp(8'h21);
        chk("isr", in_service_register, 8'h0a);
        cic_host_i.eoi();
        repeat (2) @(negedge clk);
        chk("isr", in_service_register, 8'h08);
        cic_host_i.eoi();
        repeat (4) @(negedge clk);
        chk("int", {7'h0, intr}, 8'h01);
        ack_exp(8'h25);
        cic_host_i.eoi();
        repeat (4) @(negedge clk);
        chk("isr", in_service_register, 8'h00);
        chk("int", {7'h0, intr}, 8'h00);
        ack_exp(8'h27);
        chk("isr", in_service_register, 8'h00);
        irq_set(8'h2e);
        ack_exp(8'h02);
        chk("isr", in_service_register, 8'h04);
        cic_host_i.eoi();
        repeat (2) @(negedge clk);
        chk("isr", in_service_register, 8'h00);
        rnd = lfsr(rnd);
        cic_host_i.put(1'b1, rnd);
        rd_exp(rnd);
        irq_set(8'h00);
        cic_host_i.init(8'h12, 8'h48);
        rd_exp(8'h00);
        rnd = lfsr(rnd);
        cic_host_i.put(1'b1, rnd);
        rd_exp(rnd);
        ack_exp(8'h4f);
        cic_host_i.put(1'b1, 8'hff);
        irq_set(8'h01);
        chk("int", {7'h0, intr}, 8'h00);
        chk("queue", 8'(exp_q.size()), 8'h00);
        give_verdict();
    end
endmodule // cic_core_test
`default_nettype wire
